// ---- logic/ses_ctrl.sv ----
// host controller that drives a parallel nor flash for sector erase,
// erase suspend/resume, plain writes and reads; software over axi4-lite.
// assumes word mode flash pins, 10 MHz mclk, one command at a time.
// Notes on behaviour
// - sector erase is six write cycles
// - host spaces added sectors under 50 us
// - host should mask interrupts while queuing
// - other command except read in window drops request
// - hardware reset aborts erase; host repeats
// - resume continues erase, repeats ignored
`timescale 1ns/1ps
`default_nettype none
`include "ses_regs.svh"
module ses_ctrl
  import ses_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // axi4-lite write channels
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // flash pins
  output logic [19:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_n,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_reset_n,
  input wire logic ready_busy_pin
);
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // address and data of one bus write of a command
  function automatic logic [35:0] cyc(input logic [3:0] op,
      input logic [2:0] step, input logic [19:0] a, input logic [15:0] d);
    logic [35:0] r;
    r = {a, d};
    if (op == `SES_OP_ERASE || op == `SES_OP_ADD) begin
      case (step)
        3'h0: r = {`SES_A_UNL1, `SES_D_AA};
        3'h1: r = {`SES_A_UNL2, `SES_D_55};
        3'h2: r = {`SES_A_UNL1, `SES_D_80};
        3'h3: r = {`SES_A_UNL1, `SES_D_AA};
        3'h4: r = {`SES_A_UNL2, `SES_D_55};
        default: r = {a[19:12], `SES_SA_LOW, `SES_D_30};
      endcase
    end else if (op == `SES_OP_SUSP) begin
      r = {`SES_A_ZERO, `SES_D_B0};
    end else if (op == `SES_OP_RESUME) begin
      r = {`SES_A_ZERO, `SES_D_30};
    end else if (op == `SES_OP_RESET) begin
      r = {`SES_A_ZERO, `SES_D_F0};
    end
    return r;
  endfunction

  logic [16:0] pin_q;
  ses_sync #(.W(17)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d({ready_busy_pin, fl_dq_i}),
    .q(pin_q)
  );

  // axi slave group
  logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic nxt_awready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, stat_w;
  logic wr_go, rd_go;

  assign wr_go = awready_ff & awvalid & wvalid;
  assign rd_go = arready_ff & arvalid;

  // sequencer group
  ses_state_e st_ff, nxt_st;
  logic [3:0] op_ff, nxt_op;
  logic [2:0] step_ff, last_ff, nxt_step, nxt_last;
  logic [9:0] cnt_ff, nxt_cnt, wcnt_ff, nxt_wcnt;
  logic [19:0] sa_ff, nxt_sa, addr_ff, nxt_addr;
  logic [15:0] wd_ff, nxt_wd, rdat_ff, nxt_rdat, dqo_ff, nxt_dqo;
  logic win_ff, nxt_win, eb_ff, nxt_eb, el_ff, nxt_el, ea_ff, nxt_ea;
  logic ce_ff, we_ff, oe_ff, rst_ff, dqoe_ff;
  logic nxt_ce, nxt_we, nxt_oe, nxt_rst, nxt_dqoe;
  logic busy, cmd_wr;
  logic [3:0] op_in;
  logic [35:0] ad;
  logic [31:0] mg_sa, mg_wd;

  assign busy = (st_ff != SES_IDLE);
  assign cmd_wr = wr_go && awaddr == `SES_OFF_CMD && wstrb[0];
  assign op_in = wdata[3:0];
  always_comb begin
    stat_w = '0;
    stat_w[15:0] = rdat_ff;
    stat_w[`SES_ST_BUSY] = busy;
    stat_w[`SES_ST_RYBY] = pin_q[16];
    stat_w[`SES_ST_WIN] = win_ff;
    stat_w[`SES_ST_EBUSY] = eb_ff;
    stat_w[`SES_ST_ELATE] = el_ff;
    stat_w[`SES_ST_EABORT] = ea_ff;
  end

  always_comb begin
    nxt_awready = awvalid & wvalid & ~awready_ff & ~bvalid_ff;
    nxt_arready = arvalid & ~arready_ff & ~rvalid_ff;
    nxt_bvalid = bvalid_ff & ~bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff & ~rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = (awaddr[1:0] == 2'h0) ? `SES_RESP_OK : `SES_RESP_ERR;
    end
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `SES_RESP_OK;
      case (araddr)
        `SES_OFF_CMD: nxt_rdata = {28'h000_0000, op_ff};
        `SES_OFF_ADDR: nxt_rdata = {12'h000, sa_ff};
        `SES_OFF_WDATA: nxt_rdata = {16'h0000, wd_ff};
        `SES_OFF_STAT: nxt_rdata = stat_w;
        default: begin
          nxt_rdata = '0;
          nxt_rresp = `SES_RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SES_RESP_OK;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `SES_RESP_OK;
      rdata_ff <= '0;
    end else begin
      awready_ff <= nxt_awready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_step = step_ff;
    nxt_last = last_ff;
    nxt_cnt = cnt_ff + 10'h001;
    nxt_sa = sa_ff;
    nxt_wd = wd_ff;
    nxt_rdat = rdat_ff;
    nxt_addr = addr_ff;
    nxt_dqo = dqo_ff;
    nxt_ce = ce_ff;
    nxt_we = we_ff;
    nxt_oe = oe_ff;
    nxt_rst = rst_ff;
    nxt_dqoe = dqoe_ff;
    nxt_eb = eb_ff;
    nxt_el = el_ff;
    nxt_ea = ea_ff;
    nxt_win = win_ff;
    nxt_wcnt = win_ff ? wcnt_ff + 10'h001 : wcnt_ff;
    // close early by a margin: the add cycle still needs its strobe
    if (win_ff && wcnt_ff == 10'(`SES_WIN_CYC - `SES_WIN_MARGIN - 1))
      nxt_win = 1'b0;
    ad = cyc(op_ff, step_ff + 3'h1, sa_ff, wd_ff);
    // a call result cannot be sliced directly, so merge into a word first
    mg_sa = merge({12'h000, sa_ff}, wdata, wstrb);
    mg_wd = merge({16'h0000, wd_ff}, wdata, wstrb);
    if (wr_go && awaddr == `SES_OFF_ADDR)
      nxt_sa = mg_sa[19:0];
    if (wr_go && awaddr == `SES_OFF_WDATA)
      nxt_wd = mg_wd[15:0];
    if (wr_go && awaddr == `SES_OFF_STAT && wstrb[2]) begin
      nxt_eb = eb_ff & ~wdata[`SES_ST_EBUSY];
      nxt_el = el_ff & ~wdata[`SES_ST_ELATE];
      nxt_ea = ea_ff & ~wdata[`SES_ST_EABORT];
    end
    unique case (st_ff)
      SES_IDLE: begin
        if (cmd_wr && op_in == `SES_OP_ADD && !win_ff) begin
          nxt_el = 1'b1;
        end else if (cmd_wr && op_in >= `SES_OP_ERASE &&
            op_in <= `SES_OP_HWRST) begin
          nxt_op = op_in;
          nxt_cnt = '0;
          nxt_step = (op_in == `SES_OP_ADD) ? `SES_LAST_STEP : 3'h0;
          nxt_last = (op_in == `SES_OP_ERASE || op_in == `SES_OP_ADD) ?
              `SES_LAST_STEP : 3'h0;
          ad = cyc(op_in, nxt_step, sa_ff, wd_ff);
          // commands other than add and read drop a pending request; suspend ends it
          if (op_in != `SES_OP_ADD && op_in != `SES_OP_READ)
            nxt_win = 1'b0;
          if (op_in == `SES_OP_READ) begin
            nxt_st = SES_READ;
            nxt_addr = sa_ff;
            nxt_ce = 1'b0;
            nxt_oe = 1'b0;
          end else if (op_in == `SES_OP_HWRST) begin
            nxt_st = SES_RST;
            nxt_rst = 1'b0;
            if (win_ff || !pin_q[16])
              nxt_ea = 1'b1;
          end else begin
            // a command's write cycles go out back to back; each queued sector needs its own add command
            nxt_st = SES_SETUP;
            nxt_addr = ad[35:16];
            nxt_dqo = ad[15:0];
            nxt_ce = 1'b0;
            nxt_dqoe = 1'b0;
          end
        end
      end
      SES_SETUP: begin
        nxt_we = 1'b0;
        nxt_st = SES_STROBE;
      end
      SES_STROBE: begin
        nxt_we = 1'b1;
        nxt_st = SES_HOLD;
        if (step_ff == `SES_LAST_STEP) begin
          nxt_win = 1'b1;
          nxt_wcnt = '0;
        end
      end
      SES_HOLD: begin
        if (step_ff != last_ff) begin
          nxt_step = step_ff + 3'h1;
          nxt_addr = ad[35:16];
          nxt_dqo = ad[15:0];
          nxt_st = SES_SETUP;
        end else begin
          nxt_ce = 1'b1;
          nxt_dqoe = 1'b1;
          nxt_st = SES_IDLE;
        end
      end
      SES_READ: begin
        if (cnt_ff == 10'(`SES_RD_CYC - 1)) begin
          nxt_rdat = pin_q[15:0];
          nxt_ce = 1'b1;
          nxt_oe = 1'b1;
          nxt_st = SES_IDLE;
        end
      end
      SES_RST: begin
        if (cnt_ff == 10'(`SES_RST_CYC - 1))
          nxt_rst = 1'b1;
        if (cnt_ff == 10'(`SES_RST_CYC + `SES_REC_CYC - 1))
          nxt_st = SES_IDLE;
      end
    endcase
    if (cmd_wr && busy)
      nxt_eb = 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= SES_IDLE;
      op_ff <= '0;
      step_ff <= '0;
      last_ff <= '0;
      cnt_ff <= '0;
      wcnt_ff <= '0;
      sa_ff <= '0;
      wd_ff <= '0;
      rdat_ff <= '0;
      addr_ff <= '0;
      dqo_ff <= '0;
      win_ff <= 1'b0;
      eb_ff <= 1'b0;
      el_ff <= 1'b0;
      ea_ff <= 1'b0;
      ce_ff <= 1'b1;
      we_ff <= 1'b1;
      oe_ff <= 1'b1;
      rst_ff <= 1'b1;
      dqoe_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      step_ff <= nxt_step;
      last_ff <= nxt_last;
      cnt_ff <= nxt_cnt;
      wcnt_ff <= nxt_wcnt;
      sa_ff <= nxt_sa;
      wd_ff <= nxt_wd;
      rdat_ff <= nxt_rdat;
      addr_ff <= nxt_addr;
      dqo_ff <= nxt_dqo;
      win_ff <= nxt_win;
      eb_ff <= nxt_eb;
      el_ff <= nxt_el;
      ea_ff <= nxt_ea;
      ce_ff <= nxt_ce;
      we_ff <= nxt_we;
      oe_ff <= nxt_oe;
      rst_ff <= nxt_rst;
      dqoe_ff <= nxt_dqoe;
    end
  end

  assign awready = awready_ff;
  assign wready = awready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign fl_addr = addr_ff;
  assign fl_dq_o = dqo_ff;
  assign fl_dq_oe_n = dqoe_ff;
  assign fl_ce_n = ce_ff;
  assign fl_we_n = we_ff;
  assign fl_oe_n = oe_ff;
  assign fl_reset_n = rst_ff;

  // helper: strobes seen in the current command
  logic [2:0] we_cnt_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) we_cnt_ff <= '0;
    else if (st_ff == SES_IDLE) we_cnt_ff <= '0;
    else if (st_ff == SES_STROBE) we_cnt_ff <= we_cnt_ff + 3'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_erase_six: assert property (
    st_ff == SES_HOLD && op_ff == `SES_OP_ERASE && step_ff == last_ff
    |-> we_cnt_ff == 3'h6) else $error("erase not six writes");
  a_we_one_cycle: assert property (
    $fell(fl_we_n) |-> !fl_ce_n ##1 fl_we_n && !fl_ce_n)
    else $error("write strobe not one cycle inside select");
  a_unlock_data: assert property (
    !fl_we_n && op_ff == `SES_OP_ERASE && step_ff == 3'h2
    |-> fl_dq_o == `SES_D_80 && fl_addr == `SES_A_UNL1)
    else $error("set-up cycle wrong");
  a_sector_bits: assert property (
    !fl_we_n && step_ff == `SES_LAST_STEP
    |-> fl_dq_o == `SES_D_30 && fl_addr[11:0] == `SES_SA_LOW
        && fl_addr[19:12] == sa_ff[19:12])
    else $error("sector cycle wrong");
  a_win_opens: assert property (
    $rose(fl_we_n) && step_ff == `SES_LAST_STEP |-> win_ff && wcnt_ff == 0)
    else $error("window not started at strobe rise");
  a_late_refused: assert property (
    st_ff == SES_IDLE && cmd_wr && op_in == `SES_OP_ADD && !win_ff
    |=> el_ff && st_ff == SES_IDLE) else $error("late add not refused");
  a_other_drops: assert property (
    st_ff == SES_IDLE && cmd_wr && win_ff &&
    (op_in == `SES_OP_RESET || op_in == `SES_OP_SUSP) |=> !win_ff)
    else $error("window survives other command");
  a_resume_cycle: assert property (
    !fl_we_n && op_ff == `SES_OP_RESUME
    |-> fl_dq_o == `SES_D_30 && fl_addr == `SES_A_ZERO)
    else $error("resume cycle wrong");
  a_hwrst_hold: assert property (
    st_ff == SES_IDLE && cmd_wr && op_in == `SES_OP_HWRST
    |=> (!fl_reset_n)[*5] ##1 fl_reset_n)
    else $error("reset pulse length wrong");
  a_no_drive_read: assert property (
    !fl_oe_n |-> fl_dq_oe_n) else $error("bus contention on read");

  c_erase_done: cover property (
    st_ff == SES_HOLD && op_ff == `SES_OP_ERASE && step_ff == last_ff);
  c_add_sector: cover property (
    st_ff == SES_HOLD && op_ff == `SES_OP_ADD);
  c_suspend: cover property (!fl_we_n && op_ff == `SES_OP_SUSP);
  c_abort: cover property ($rose(ea_ff));
endmodule
`default_nettype wire

// ---- logic/ses_regs.svh ----
// constants for the sector erase host controller: offsets, codes, timing
// assumes a 10 MHz mclk; included by bare name
`ifndef SES_REGS_SVH
`define SES_REGS_SVH
// axi4-lite register offsets
`define SES_OFF_CMD 4'h0
`define SES_OFF_ADDR 4'h4
`define SES_OFF_WDATA 4'h8
`define SES_OFF_STAT 4'hC
`define SES_RESP_OK 2'h0
`define SES_RESP_ERR 2'h2
// command field values, cmd[3:0]
`define SES_OP_ERASE 4'h1
`define SES_OP_ADD 4'h2
`define SES_OP_SUSP 4'h3
`define SES_OP_RESUME 4'h4
`define SES_OP_RESET 4'h5
`define SES_OP_READ 4'h6
`define SES_OP_WRITE 4'h7
`define SES_OP_HWRST 4'h8
// status bit positions; bits 15:0 hold the last read word
`define SES_ST_BUSY 16
`define SES_ST_RYBY 17
`define SES_ST_WIN 18
`define SES_ST_EBUSY 19
`define SES_ST_ELATE 20
`define SES_ST_EABORT 21
// flash word-mode addresses and data
`define SES_A_UNL1 20'h0_0555
`define SES_A_UNL2 20'h0_02AA
`define SES_A_ZERO 20'h0_0000
`define SES_SA_LOW 12'h000
`define SES_D_AA 16'h00AA
`define SES_D_55 16'h0055
`define SES_D_80 16'h0080
`define SES_D_30 16'h0030
`define SES_D_B0 16'h00B0
`define SES_D_F0 16'h00F0
`define SES_LAST_STEP 3'h5
// timing
`define SES_CLK_NS 100
`define SES_WIN_NS 50000
`define SES_WIN_CYC (`SES_WIN_NS / `SES_CLK_NS)
`define SES_WIN_MARGIN 4
`define SES_RST_NS 500
`define SES_RST_CYC ((`SES_RST_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)
`define SES_REC_NS 1000
`define SES_REC_CYC ((`SES_REC_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)
`define SES_RD_NS 400
`define SES_RD_CYC ((`SES_RD_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)
`endif

// ---- logic/ses_pkg.sv ----
// types for the sector erase host controller
// assumes nothing beyond the constants header
package ses_pkg;
  typedef enum logic [2:0] {
    SES_IDLE, SES_SETUP, SES_STROBE, SES_HOLD, SES_READ, SES_RST
  } ses_state_e;
endpackage

// ---- logic/ses_sync.sv ----
// two-flop synchroniser for the flash pin inputs
// assumes inputs asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module ses_sync #(
  parameter int W = 17
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff, q_ff;
  logic [W-1:0] nxt_s1, nxt_q;
  always_comb begin
    nxt_s1 = d;
    nxt_q = s1_ff;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      q_ff <= nxt_q;
    end
  end
  assign q = q_ff;
endmodule
`default_nettype wire

// ---- testbench/ses_flash_mdl.sv ----
// behavioural word-mode nor flash: sector erase window, suspend, resume
// assumes strobes from ses_ctrl; data latches at the rise of we_n
`timescale 1ns/1ps
`default_nettype none
module ses_flash_mdl #(
  parameter int ERASE_NS = 100000,
  // identification word; the value is arbitrary
  parameter logic [15:0] ID_CODE = 16'h5A3C
) (
  // strobes
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_n,
  // bus
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic ryby
);
  logic [7:0] seq [5] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
  // no sector is protected here, so none is skipped
  logic [255:0] sel = '0;
  logic [2:0] step = 3'h0;
  logic win = 1'b0;
  logic ers = 1'b0;
  logic susp = 1'b0;
  logic ids = 1'b0;
  logic tog = 1'b0;
  logic [15:0] val;
  logic [15:0] last = 16'h0000;
  logic [10:0] ua;
  time t_w, t_e;
  assign ua = (step == 3'h1 || step == 3'h4) ? 11'h2AA : 11'h555;
  // array content is an address pattern so reads can be predicted
  always_comb begin
    val = addr[15:0] ^ 16'hA5A5;
    if ((win || ers) && (!susp || sel[addr[19:12]])) begin
      val = {8'h00, susp, susp | tog, 2'b00, ers, tog, 2'b00};
    end
    if (ids) val = ID_CODE;
  end
  // a released bus shows the inverse of its last value, never a hold
  assign dq_out = (!ce_n && !oe_n) ? val : ~last;
  assign ryby = !(win || ers) || susp;
  always @(posedge oe_n) last = val;
  always @(negedge oe_n) tog = !tog;
  always @(posedge we_n or negedge reset_n) begin
    if (!reset_n) begin
      {step, win, ers, susp} = '0;
      ids = 1'b0;
      sel = '0;
    end else if (!ce_n) begin
      if (susp) begin
        // other writes are ignored; pattern kept
        if (dq_in[7:0] == 8'h90) begin
          ids = 1'b1;
        end else if (dq_in[7:0] == 8'hF0) begin
          ids = 1'b0;
        end else if (dq_in[7:0] == 8'h30 && !ids) begin
          susp = 1'b0;
          t_e = $time;
        end
      end else if (ers) begin
        susp = (dq_in[7:0] == 8'hB0);
      end else if (win) begin
        if (dq_in[7:0] == 8'h30) begin
          sel[addr[19:12]] = 1'b1;
          t_w = $time;
        end else if (dq_in[7:0] == 8'hB0) begin
          {win, ers, susp} = 3'b011;
          t_e = $time;
        end else begin
          win = 1'b0;
          sel = '0;
        end
      end else if (step == 3'h5 && dq_in[7:0] == 8'h30) begin
        sel[addr[19:12]] = 1'b1;
        win = 1'b1;
        t_w = $time;
        step = 3'h0;
      end else if (step < 3'h5 && dq_in[7:0] == seq[step] &&
          addr[10:0] == ua) begin
        step = step + 3'h1;
      end else begin
        step = 3'h0;
      end
    end
  end
  // 1 us poll is cheap; the window may close up to 1 us late
  always #1000 begin
    if (win && $time - t_w >= 50000) begin
      win = 1'b0;
      ers = 1'b1;
      t_e = $time;
    end
    if (ers && !susp && $time - t_e >= ERASE_NS) begin
      ers = 1'b0;
      sel = '0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// bench for ses_ctrl: axi4-lite master tasks, flash model, strobe log
// assumes ses_regs.svh offsets, op codes and status bit positions
`timescale 1ns/1ps
`default_nettype none
`include "ses_regs.svh"
module tb;
  typedef struct {logic [19:0] a; logic [15:0] d;} ses_row_s;
  logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, st;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, br;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_o, m_dq, dq_w;
  logic fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, ryby;
  int fails, cmp_count, rst_low, n0;
  logic [19:0] la[$];
  logic [15:0] ld[$];
  ses_row_s rows[3] = '{'{20'h0_0000, 16'hA5A5},
    '{20'h1_2345, 16'h86E0}, '{20'hF_FFFF, 16'h5A5A}};
  logic [19:0] ea[6] = '{20'h0_0555, 20'h0_02AA, 20'h0_0555,
    20'h0_0555, 20'h0_02AA, 20'h1_2000};
  logic [15:0] ed[6] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA,
    16'h0055, 16'h0030};
  assign dq_w = fl_dq_oe_n ? m_dq : fl_dq_o;
  ses_ctrl i_dut (.mclk, .nrst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fl_addr,
    .fl_dq_o, .fl_dq_oe_n, .fl_dq_i(dq_w), .fl_ce_n, .fl_we_n,
    .fl_oe_n, .fl_reset_n, .ready_busy_pin(ryby));
  ses_flash_mdl #(.ERASE_NS(100000)) i_flash (.ce_n(fl_ce_n),
    .we_n(fl_we_n), .oe_n(fl_oe_n), .reset_n(fl_reset_n),
    .addr(fl_addr), .dq_in(dq_w), .dq_out(m_dq), .ryby(ryby));
  always @(posedge fl_we_n) begin
    if (fl_ce_n === 1'b0) begin
      la.push_back(fl_addr);
      ld.push_back(fl_dq_o);
    end
  end
  always @(posedge mclk) begin
    if (fl_reset_n === 1'b0) rst_low++;
  end
  task automatic complete_run;
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return awready & wready;
      1: return bvalid;
      2: return arready;
      default: return rvalid;
    endcase
  endfunction
  task automatic waitf(input int w);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sig(w) !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    waitf(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    waitf(1);
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    waitf(2);
    arvalid <= 1'b0;
    rready <= 1'b1;
    waitf(3);
    st = rdata;
    br = rresp;
    rready <= 1'b0;
  endtask
  // launch an op, then poll busy; st keeps the last status word
  task automatic op(input logic [3:0] c);
    int n;
    n = 0;
    axw(`SES_OFF_CMD, {28'h0, c});
    do begin
      axr(`SES_OFF_STAT);
      n++;
    end while (st[`SES_ST_BUSY] !== 1'b0 && n < 30);
    if (n >= 30) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [19:0] a);
    axw(`SES_OFF_ADDR, {12'h000, a});
    op(`SES_OP_READ);
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    axr(`SES_OFF_STAT);
    chk("stat_rst", 32'h0002_0000, st);
    axw(4'h1, 32'h0);
    chk("bresp_unaligned", 32'h0000_0002, 32'(br));
    axr(4'h1);
    chk("rresp_unmapped", 32'h0000_0002, 32'(br));
    chk("rdata_unmapped", 32'h0000_0000, st);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk("array_rd", 32'(rows[i].d), 32'(st[15:0]));
    end
    axr(`SES_OFF_ADDR);
    chk("addr_reg", 32'h000F_FFFF, st);
    axr(`SES_OFF_CMD);
    chk("cmd_reg", 32'h0000_0006, st);
    la.delete();
    ld.delete();
    axw(`SES_OFF_ADDR, 32'h0001_2FFF);
    op(`SES_OP_ERASE);
    chk("win_open", 32'h1, 32'(st[`SES_ST_WIN]));
    foreach (ea[i]) begin
      chk("seq_a", 32'(ea[i]), 32'(la[i]));
      chk("seq_d", 32'(ed[i]), 32'(ld[i]));
    end
    axw(`SES_OFF_ADDR, 32'h0000_5000);
    op(`SES_OP_ADD);
    chk("add_a", 32'h0000_5000, 32'(la[6]));
    chk("add_d", 32'h0000_0030, 32'(ld[6]));
    rd(20'h1_2000);
    chk("win_stat", 32'h0, 32'({st[7], st[3]}));
    op(`SES_OP_SUSP);
    rd(20'h0_5000);
    chk("susp_stat", 32'h1, 32'(st[7]));
    rd(20'h2_0010);
    chk("susp_array", 32'h0000_A5B5, 32'(st[15:0]));
    op(`SES_OP_RESUME);
    op(`SES_OP_RESUME);
    rd(20'h0_5000);
    chk("erase_stat", 32'h1, 32'({st[7], st[3]}));
    chk("busy_pin", 32'h0, 32'(st[`SES_ST_RYBY]));
    op(`SES_OP_SUSP);
    rd(20'h1_2000);
    chk("susp_again", 32'h1, 32'(st[7]));
    axw(`SES_OFF_WDATA, 32'h0000_0090);
    op(`SES_OP_WRITE);
    rd(20'h1_2000);
    chk("id_code", 32'h0000_5A3C, 32'(st[15:0]));
    op(`SES_OP_RESET);
    rd(20'h1_2000);
    chk("id_exit", 32'h1, 32'(st[7]));
    op(`SES_OP_RESUME);
    repeat (1100) @(posedge mclk);
    rd(20'h1_2000);
    chk("done_array", 32'h0000_85A5, 32'(st[15:0]));
    chk("ready_pin", 32'h1, 32'(st[`SES_ST_RYBY]));
    axw(`SES_OFF_ADDR, 32'h0003_0000);
    op(`SES_OP_ERASE);
    repeat (600) @(posedge mclk);
    n0 = la.size();
    op(`SES_OP_ADD);
    chk("late_flag", 32'h1, 32'(st[`SES_ST_ELATE]));
    chk("late_cyc", 32'(n0), 32'(la.size()));
    axw(`SES_OFF_STAT, 32'h0010_0000);
    axr(`SES_OFF_STAT);
    chk("late_clr", 32'h0, 32'(st[`SES_ST_ELATE]));
    op(`SES_OP_RESET);
    rd(20'h3_0000);
    chk("busy_ignore", 32'h0, 32'(st[7]));
    repeat (1100) @(posedge mclk);
    axw(`SES_OFF_ADDR, 32'h0004_0000);
    op(`SES_OP_ERASE);
    axw(`SES_OFF_WDATA, 32'h0000_1234);
    op(`SES_OP_WRITE);
    rd(20'h4_0000);
    chk("drop_rd", 32'h0000_A5A5, 32'(st[15:0]));
    axw(`SES_OFF_ADDR, 32'h0005_0000);
    axw(`SES_OFF_CMD, {28'h0, `SES_OP_ERASE});
    op(`SES_OP_RESET);
    chk("busy_refused", 32'h1, 32'(st[`SES_ST_EBUSY]));
    rst_low = 0;
    op(`SES_OP_HWRST);
    chk("abort_flag", 32'h1, 32'(st[`SES_ST_EABORT]));
    chk("rst_width", 32'h5, 32'(rst_low));
    rd(20'h5_0000);
    chk("abort_rd", 32'h0000_A5A5, 32'(st[15:0]));
    axw(`SES_OFF_CMD, 32'h0000_0006);
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    chk("rst_pins", 32'hF, 32'({fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n}));
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    complete_run();
  end
endmodule
`default_nettype wire
